// ### rtl/psb_pkg.sv
package psb_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // analog levels are carried as millivolt codes
  localparam int MV_W   = 13;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PERIOD   = 8'h04;
  localparam logic [7:0] ADDR_DEL_AB   = 8'h08;
  localparam logic [7:0] ADDR_DEL_CD   = 8'h0c;
  localparam logic [7:0] ADDR_SS_DIV   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;
  localparam logic [7:0] ADDR_SS_LEVEL = 8'h18;

  // control field positions and modes
  localparam int CTRL_W          = 5;
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_AB_DEFEAT  = 2;
  localparam int CTRL_CD_DEFEAT  = 3;
  localparam int CTRL_SYNC_SLAVE = 4;
  localparam logic [1:0] MODE_VOLTAGE = 2'h0;
  localparam logic [1:0] MODE_AVERAGE = 2'h1;
  localparam logic [1:0] MODE_PEAK    = 2'h2;

  // values after reset
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  localparam logic [15:0] DEL_RST    = 16'h2710;
  localparam logic [15:0] SS_DIV_RST = 16'h0028;

  // dead time: 25e-12 s*ohm/V is 25 ns per ohm/mV, plus a fixed part
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEL_NS_OHM_MV = 25;
  localparam int DEL_FIXED_NS  = 25;

  // thresholds in millivolts
  localparam logic [12:0] NOLOAD_OFF_MV = 13'h1f4;
  localparam logic [12:0] NOLOAD_ON_MV  = 13'h258;
  localparam logic [12:0] SS_LOW_MV     = 13'h1f4;
  localparam logic [12:0] REF_LOW_MV    = 13'hfa0;
  localparam logic [12:0] CS_PEAK_MV    = 13'h7d0;
  localparam logic [12:0] CS_OC_MV      = 13'h9c4;
  localparam logic [12:0] CT_PEAK_MV    = 13'h92e;
  localparam logic [12:0] VDEL_MIN_MV   = 13'h1f4;
  localparam logic [12:0] VDEL_MAX_MV   = 13'h7d0;
  localparam logic [12:0] SS_MAX_MV     = 13'h1388;
  // soft-start sources one unit, soft-stop sinks ten units
  localparam logic [12:0] SS_SRC_STEP   = 13'h001;
  localparam logic [12:0] SS_SINK_STEP  = 13'h00a;

  typedef enum logic [4:0] {
    ST_SUPPLY_UNDERVOLTAGE_LOCKOUT = 5'b00001,
    ST_DIS  = 5'b00010,
    ST_SS   = 5'b00100,
    ST_RUN  = 5'b01000,
    ST_STOP = 5'b10000
  } psb_state_e;
endpackage

// ### rtl/psb_dead_time.sv
`timescale 1ns/100ps
`default_nettype none
module psb_dead_time #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic             phase,
  input  wire logic [CNT_W-1:0] dead_cyc,
  output var  logic             out_hi,
  output var  logic             out_lo
);
  logic             applied_reg;
  logic [CNT_W-1:0] cnt_reg;

  // a phase change opens a gap of dead_cyc cycles with both legs low
  wire logic moved  = (phase != applied_reg);
  wire logic no_gap = (dead_cyc == {CNT_W{1'b0}});

  // enable loss drops both legs on the next edge, no cycle boundary wait
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      applied_reg <= 1'b0;
      cnt_reg     <= {CNT_W{1'b0}};
      out_hi      <= 1'b0;
      out_lo      <= 1'b0;
    end else if (!en) begin
      applied_reg <= phase;
      cnt_reg     <= {CNT_W{1'b0}};
      out_hi      <= 1'b0;
      out_lo      <= 1'b0;
    end else if (moved) begin
      applied_reg <= phase;
      cnt_reg     <= no_gap ? {CNT_W{1'b0}} : dead_cyc - 1'b1;
      out_hi      <= no_gap & phase;
      out_lo      <= no_gap & ~phase;
    end else if (cnt_reg != {CNT_W{1'b0}}) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      out_hi <= applied_reg;
      out_lo <= ~applied_reg;
    end
  end

  a_gap_both_low: assert property (@(posedge clk) disable iff (rst)
    en && moved && !no_gap |=> !out_hi && !out_lo)
    else $error("dead time gap missing");
  a_pair_exclusive: assert property (@(posedge clk) disable iff (rst)
    !(out_hi && out_lo))
    else $error("both legs of a pair high");
endmodule
`default_nettype wire

// ### rtl/psb_bridge_pwm.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module psb_bridge_pwm #(
  parameter int CNT_W = 16
) (
  input  wire logic                       CLOCK,
  input  wire logic                       SYS_RST,
  input  wire logic [psb_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [psb_pkg::DATA_W-1:0] WDATA,
  input  wire logic                       WR_STB,
  input  wire logic                       RD_STB,
  output var  logic [psb_pkg::DATA_W-1:0] RDATA,
  input  wire logic [psb_pkg::MV_W-1:0]   ERROR_AMP_OUTPUT_MV,
  input  wire logic [psb_pkg::MV_W-1:0]   RAMP_INPUT_MV,
  input  wire logic [psb_pkg::MV_W-1:0]   CURRENT_SENSE_MV,
  input  wire logic [psb_pkg::MV_W-1:0]   ADAPTIVE_DELAY_LEVEL_MV,
  input  wire logic [psb_pkg::MV_W-1:0]   REFERENCE_MV,
  input  wire logic                       SOFTSTART_DISABLE_PIN_FORCED_LOW,
  input  wire logic                       SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input  wire logic                       SYNC_IN,
  output var  logic                       SYNC_OUT,
  output var  logic                       SYNC_OE,
  output var  logic                       BRIDGE_LEG1_HIGH,
  output var  logic                       BRIDGE_LEG1_LOW,
  output var  logic                       BRIDGE_LEG2_HIGH,
  output var  logic                       BRIDGE_LEG2_LOW,
  output var  logic                       REFERENCE_ENABLE,
  output var  logic                       LOW_SUPPLY_CURRENT_MODE,
  output var  logic                       SOFTSTART_DISABLE_PIN_DISCHARGE,
  output var  logic                       SOFTSTART_DISABLE_PIN_SOURCE,
  output var  logic                       SOFTSTART_DISABLE_PIN_SINK
);
  import psb_pkg::*;

  // software state
  logic [CTRL_W-1:0] ctrl_reg;
  logic [15:0]       period_reg;
  logic [15:0]       del_ab_reg;
  logic [15:0]       del_cd_reg;
  logic [15:0]       ss_div_reg;
  // oscillator and phase state
  logic [15:0]       ramp_reg;
  logic [15:0]       ramp_next;
  logic              sync_d_reg;
  logic              phase_ab_reg;
  logic              phase_cd_reg;
  logic              tripped_reg;
  logic              noload_reg;
  // soft-start sequencing
  psb_state_e        st_reg;
  psb_state_e        st_next;
  logic [MV_W-1:0]   ss_reg;
  logic [MV_W-1:0]   ss_next;
  logic [15:0]       ss_div_cnt_reg;

  // cycles = ceil((25*R/Vmv + 25) ns / clock period)
  function automatic logic [CNT_W-1:0] dead_cycles(input logic [15:0] r_ohm,
                                                   input logic [12:0] v_mv);
    logic [31:0] num;
    logic [31:0] den;
    num = 32'(r_ohm) * 32'(DEL_NS_OHM_MV) + 32'(DEL_FIXED_NS) * 32'(v_mv);
    den = 32'(v_mv) * 32'(CLK_PERIOD_NS);
    return CNT_W'((num + den - 32'h1) / den);
  endfunction

  // register decode
  wire logic wr_ctrl   = WR_STB && (ADDR == ADDR_CTRL);
  wire logic wr_period = WR_STB && (ADDR == ADDR_PERIOD);
  wire logic wr_del_ab = WR_STB && (ADDR == ADDR_DEL_AB);
  wire logic wr_del_cd = WR_STB && (ADDR == ADDR_DEL_CD);
  wire logic wr_ss_div = WR_STB && (ADDR == ADDR_SS_DIV);

  wire logic [1:0] mode     = ctrl_reg[CTRL_MODE_LSB +: 2];
  wire logic       slave    = ctrl_reg[CTRL_SYNC_SLAVE];
  wire logic       peak_md  = (mode == MODE_PEAK);

  // control registers; a period of zero would stall the ramp, so keep >= 1
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg   <= CTRL_RST;
      period_reg <= PERIOD_RST;
      del_ab_reg <= DEL_RST;
      del_cd_reg <= DEL_RST;
      ss_div_reg <= SS_DIV_RST;
    end else begin
      if (wr_ctrl)   ctrl_reg   <= WDATA[CTRL_W-1:0];
      if (wr_period) period_reg <= (WDATA[15:0] == 16'h0) ? 16'h1 : WDATA[15:0];
      if (wr_del_ab) del_ab_reg <= WDATA[15:0];
      if (wr_del_cd) del_cd_reg <= WDATA[15:0];
      if (wr_ss_div) ss_div_reg <= WDATA[15:0];
    end
  end

  // fault and threshold detection, all combinational so shutdown is fast
  wire logic ref_low   = (REFERENCE_MV < REF_LOW_MV);
  wire logic supply_undervoltage_lockout      = SUPPLY_UNDERVOLTAGE_LOCKOUT;
  wire logic forced    = SOFTSTART_DISABLE_PIN_FORCED_LOW;
  wire logic hard_flt  = supply_undervoltage_lockout || ref_low || forced;
  wire logic overcur   = (CURRENT_SENSE_MV >= CS_OC_MV);

  // error amp can never exceed the soft-start pin level
  wire logic [MV_W-1:0] ea_eff =
    (ERROR_AMP_OUTPUT_MV < ss_reg) ? ERROR_AMP_OUTPUT_MV : ss_reg;

  // oscillator: ramp counter, terminal count gives one clock pulse
  wire logic tc        = (ramp_reg >= period_reg - 16'h1);
  wire logic sync_rise = SYNC_IN && !sync_d_reg;
  wire logic osc_pulse = slave ? sync_rise : tc;

  // external sync is level-sensitive: ramp held discharged while high
  always_comb begin
    if (slave && SYNC_IN) begin
      ramp_next = 16'h0;
    end else if (tc) begin
      ramp_next = slave ? ramp_reg : 16'h0;
    end else begin
      ramp_next = ramp_reg + 16'h1;
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ramp_reg   <= 16'h0;
      sync_d_reg <= 1'b0;
    end else begin
      ramp_reg   <= ramp_next;
      sync_d_reg <= SYNC_IN;
    end
  end

  // internal clock drives the sync pin when free-running
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SYNC_OUT <= 1'b0;
      SYNC_OE  <= 1'b0;
    end else begin
      SYNC_OUT <= !slave && tc;
      SYNC_OE  <= !slave;
    end
  end

  // timing-capacitor sawtooth scaled to its peak, compared by cross products
  wire logic [31:0] ct_scaled = 32'(ramp_reg) * 32'(CT_PEAK_MV);
  wire logic [31:0] ea_scaled = 32'(ea_eff) * 32'(period_reg);
  wire logic ct_cross   = (ct_scaled >= ea_scaled);
  wire logic ramp_cross = (RAMP_INPUT_MV >= ea_eff);
  wire logic cs_limit   = (CURRENT_SENSE_MV >= CS_PEAK_MV);
  wire logic pwm_trip   = peak_md ? (ramp_cross || cs_limit) : ct_cross;

  // leg 2 flips once per oscillator cycle: at the trip, or at cycle end
  // if the ramp never crossed; a moving trip point stretches its duty
  wire logic cd_toggle  = !tripped_reg && (pwm_trip || osc_pulse);

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_ab_reg <= 1'b0;
      phase_cd_reg <= 1'b0;
      tripped_reg  <= 1'b0;
    end else begin
      if (osc_pulse) phase_ab_reg <= !phase_ab_reg;
      if (cd_toggle) phase_cd_reg <= !phase_cd_reg;
      tripped_reg <= osc_pulse ? 1'b0 : (tripped_reg || cd_toggle);
    end
  end

  // no-load comparator with hysteresis
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      noload_reg <= 1'b1;
    end else if (ea_eff < NOLOAD_OFF_MV) begin
      noload_reg <= 1'b1;
    end else if (ea_eff > NOLOAD_ON_MV) begin
      noload_reg <= 1'b0;
    end
  end

  // adaptive delay voltage: 0.5 V + 0.75*(cs - ads), 0.5 V to 2 V
  wire logic [14:0] cs_ads = (CURRENT_SENSE_MV > ADAPTIVE_DELAY_LEVEL_MV) ?
    15'(CURRENT_SENSE_MV - ADAPTIVE_DELAY_LEVEL_MV) : 15'h0;
  wire logic [14:0] vdel_raw = 15'(VDEL_MIN_MV) + 15'((cs_ads * 15'h3) >> 2);
  wire logic [12:0] vdel_mv  =
    (vdel_raw > 15'(VDEL_MAX_MV)) ? VDEL_MAX_MV : vdel_raw[12:0];

  // a defeated pair switches with no gap at all
  wire logic [CNT_W-1:0] dead_ab = ctrl_reg[CTRL_AB_DEFEAT] ?
    {CNT_W{1'b0}} : dead_cycles(del_ab_reg, vdel_mv);
  wire logic [CNT_W-1:0] dead_cd = ctrl_reg[CTRL_CD_DEFEAT] ?
    {CNT_W{1'b0}} : dead_cycles(del_cd_reg, vdel_mv);

  // output gate: faults kill it in the same cycle they appear
  wire logic running = (st_reg == ST_SS) || (st_reg == ST_RUN);
  wire logic out_en  = running && !noload_reg && !hard_flt && !overcur;

  // sequencing: undervoltage first, then disables, then soft-start cycle
  always_comb begin
    st_next = st_reg;
    if (supply_undervoltage_lockout) begin
      st_next = ST_SUPPLY_UNDERVOLTAGE_LOCKOUT;
    end else if (ref_low || forced) begin
      st_next = ST_DIS;
    end else begin
      case (st_reg)
        ST_SUPPLY_UNDERVOLTAGE_LOCKOUT: st_next = ST_SS;
        ST_DIS:  st_next = ST_SS;
        ST_SS: begin
          if (overcur) begin
            st_next = ST_STOP;
          end else if (ss_reg >= SS_MAX_MV) begin
            st_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (overcur) begin
            st_next = ST_STOP;
          end
        end
        ST_STOP: begin
          if (ss_reg < SS_LOW_MV) begin
            st_next = ST_SS;
          end
        end
        default: st_next = ST_SUPPLY_UNDERVOLTAGE_LOCKOUT;
      endcase
    end
  end

  // slope divider: one enable pulse per ss_div_reg+1 clocks
  wire logic ss_tick = (ss_div_cnt_reg >= ss_div_reg);

  // soft-start pin level as a digital ramp; discharged in any disable
  always_comb begin
    ss_next = ss_reg;
    case (st_next)
      ST_SS: begin
        if (ss_tick) begin
          ss_next = (ss_reg >= SS_MAX_MV) ? SS_MAX_MV : ss_reg + SS_SRC_STEP;
        end
      end
      ST_STOP: begin
        if (ss_tick) begin
          ss_next = (ss_reg > SS_SINK_STEP) ? ss_reg - SS_SINK_STEP : {MV_W{1'b0}};
        end
      end
      ST_RUN:  ss_next = ss_reg;
      default: ss_next = {MV_W{1'b0}};
    endcase
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_reg         <= ST_SUPPLY_UNDERVOLTAGE_LOCKOUT;
      ss_reg         <= {MV_W{1'b0}};
      ss_div_cnt_reg <= 16'h0;
    end else begin
      st_reg         <= st_next;
      ss_reg         <= ss_next;
      ss_div_cnt_reg <= ss_tick ? 16'h0 : ss_div_cnt_reg + 16'h1;
    end
  end

  // pin current controls are decoded from the next state and the fault inputs, so they move with it
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REFERENCE_ENABLE                <= 1'b0;
      LOW_SUPPLY_CURRENT_MODE         <= 1'b1;
      SOFTSTART_DISABLE_PIN_DISCHARGE <= 1'b1;
      SOFTSTART_DISABLE_PIN_SOURCE    <= 1'b0;
      SOFTSTART_DISABLE_PIN_SINK      <= 1'b0;
    end else begin
      REFERENCE_ENABLE                <= (st_next != ST_SUPPLY_UNDERVOLTAGE_LOCKOUT);
      LOW_SUPPLY_CURRENT_MODE         <= (st_next == ST_SUPPLY_UNDERVOLTAGE_LOCKOUT);
      SOFTSTART_DISABLE_PIN_DISCHARGE <= supply_undervoltage_lockout || ref_low;
      SOFTSTART_DISABLE_PIN_SOURCE    <= (st_next == ST_SS) ||
                                         (st_next == ST_DIS && !ref_low);
      SOFTSTART_DISABLE_PIN_SINK      <= (st_next == ST_STOP);
    end
  end

  // dead-time generators, one per bridge leg
  psb_dead_time #(
    .CNT_W (CNT_W)
  ) u_leg1 (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .en       (out_en),
    .phase    (phase_ab_reg),
    .dead_cyc (dead_ab),
    .out_hi   (BRIDGE_LEG1_HIGH),
    .out_lo   (BRIDGE_LEG1_LOW)
  );

  psb_dead_time #(
    .CNT_W (CNT_W)
  ) u_leg2 (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .en       (out_en),
    .phase    (phase_cd_reg),
    .dead_cyc (dead_cd),
    .out_hi   (BRIDGE_LEG2_HIGH),
    .out_lo   (BRIDGE_LEG2_LOW)
  );

  // read mux; unmapped addresses read zero
  wire logic [31:0] status_word = {20'h0, BRIDGE_LEG2_LOW, BRIDGE_LEG2_HIGH,
    BRIDGE_LEG1_LOW, BRIDGE_LEG1_HIGH, phase_cd_reg, phase_ab_reg,
    noload_reg, st_reg};
  wire logic [31:0] rd_mux =
    (ADDR == ADDR_CTRL)     ? 32'(ctrl_reg)   :
    (ADDR == ADDR_PERIOD)   ? 32'(period_reg) :
    (ADDR == ADDR_DEL_AB)   ? 32'(del_ab_reg) :
    (ADDR == ADDR_DEL_CD)   ? 32'(del_cd_reg) :
    (ADDR == ADDR_SS_DIV)   ? 32'(ss_div_reg) :
    (ADDR == ADDR_STATUS)   ? status_word     :
    (ADDR == ADDR_SS_LEVEL) ? 32'(ss_reg)     : 32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD_STB ? rd_mux : 32'h0;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_fault_outs_low: assert property (
    hard_flt || overcur |=> !BRIDGE_LEG1_HIGH && !BRIDGE_LEG1_LOW &&
                            !BRIDGE_LEG2_HIGH && !BRIDGE_LEG2_LOW)
    else $error("outputs not forced low on fault");
  a_noload_set: assert property (
    ea_eff < NOLOAD_OFF_MV |=> noload_reg ##1 !BRIDGE_LEG1_HIGH && !BRIDGE_LEG2_HIGH)
    else $error("no-load shutdown missed");
  a_noload_hold: assert property (
    noload_reg && ea_eff <= NOLOAD_ON_MV |=> noload_reg)
    else $error("no-load released below upper threshold");
  a_ref_off_supply_undervoltage_lockout: assert property (
    supply_undervoltage_lockout |=> !REFERENCE_ENABLE && LOW_SUPPLY_CURRENT_MODE && ss_reg == 13'h0)
    else $error("reference or pin not off in lockout");
  a_ref_on_disable: assert property (
    !supply_undervoltage_lockout && forced |=> REFERENCE_ENABLE && SOFTSTART_DISABLE_PIN_SOURCE)
    else $error("reference dropped outside lockout");
  a_ref_loss_dis: assert property (
    !supply_undervoltage_lockout && ref_low |=> SOFTSTART_DISABLE_PIN_DISCHARGE && st_reg == ST_DIS)
    else $error("pin not discharged on reference loss");
  a_soft_stop_in: assert property (
    !hard_flt && overcur && st_reg == ST_RUN |=> st_reg == ST_STOP ##1 SOFTSTART_DISABLE_PIN_SINK)
    else $error("soft stop not started");
  a_soft_stop_out: assert property (
    !hard_flt && st_reg == ST_STOP && ss_reg < SS_LOW_MV |=> st_reg == ST_SS)
    else $error("soft stop did not hand over to soft start");
  a_sync_out: assert property (
    !slave && tc |=> SYNC_OUT && SYNC_OE && ramp_reg == 16'h0)
    else $error("internal clock not on sync pin");
  a_sync_reset: assert property (
    slave && SYNC_IN && !$past(SYNC_IN) |=> ramp_reg == 16'h0 && phase_ab_reg != $past(phase_ab_reg))
    else $error("sync pulse did not reset ramp");
  a_ea_clamped: assert property (
    ERROR_AMP_OUTPUT_MV > ss_reg && ss_reg < NOLOAD_OFF_MV |=> noload_reg)
    else $error("error amp not clamped to pin level");
endmodule
`default_nettype wire

// ### tb/psb_gate_stage.sv
`timescale 1ns/100ps
`default_nettype none
// gate-drive stage on the bridge side, plus a peer that can own the sync pin
module psb_gate_stage (
  input  wire logic clk,
  input  wire logic l1h,
  input  wire logic l1l,
  input  wire logic l2h,
  input  wire logic l2l,
  input  wire logic sync_oe,
  input  wire logic sync_out,
  input  wire logic peer_en,
  output var  logic sync_pin,
  output var  int   overlap
);
  int   cnt;
  logic peer_drv;
  // peer clock: one high cycle every 80 clocks, silent when disabled
  always_ff @(posedge clk) begin
    cnt <= (!peer_en || cnt == 79) ? 0 : cnt + 1;
    peer_drv <= peer_en && cnt == 79;
  end
  // pin resolved from both drivers; pull-down when neither drives
  assign sync_pin = sync_oe ? sync_out : peer_drv;
  // both switches of a leg on at once would short the rail
  always_ff @(posedge clk) begin
    if ((l1h && l1l) || (l2h && l2l)) overlap <= overlap + 1;
  end
endmodule
`default_nettype wire

// ### tb/tb_psb_bridge_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module tb_psb_bridge_pwm;
  import psb_pkg::*;
  logic        clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, forced = 0, supply_undervoltage_lockout = 0, peer = 0;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [12:0] ea = 13'h7d0, ramp = 0, cs = 0, adaptive_delay_level = 0, vref = 13'h1388;
  logic        sync_pin, sync_out, sync_oe, l1h, l1l, l2h, l2l, ref_en, lowi, dis, src, snk;
  int          err_total = 0, num_checks = 0, ov, n;

  always #12.5 clk = ~clk;

  psb_bridge_pwm u_psb_bridge_pwm (.CLOCK(clk), .SYS_RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .ERROR_AMP_OUTPUT_MV(ea),
    .RAMP_INPUT_MV(ramp), .CURRENT_SENSE_MV(cs), .ADAPTIVE_DELAY_LEVEL_MV(adaptive_delay_level),
    .REFERENCE_MV(vref), .SOFTSTART_DISABLE_PIN_FORCED_LOW(forced),
    .SUPPLY_UNDERVOLTAGE_LOCKOUT(supply_undervoltage_lockout), .SYNC_IN(sync_pin), .SYNC_OUT(sync_out),
    .SYNC_OE(sync_oe), .BRIDGE_LEG1_HIGH(l1h), .BRIDGE_LEG1_LOW(l1l), .BRIDGE_LEG2_HIGH(l2h),
    .BRIDGE_LEG2_LOW(l2l), .REFERENCE_ENABLE(ref_en), .LOW_SUPPLY_CURRENT_MODE(lowi),
    .SOFTSTART_DISABLE_PIN_DISCHARGE(dis), .SOFTSTART_DISABLE_PIN_SOURCE(src),
    .SOFTSTART_DISABLE_PIN_SINK(snk));
  psb_gate_stage u_psb_gate_stage (.clk(clk), .l1h(l1h), .l1l(l1l), .l2h(l2h), .l2l(l2l),
    .sync_oe(sync_oe), .sync_out(sync_out), .peer_en(peer), .sync_pin(sync_pin),
    .overlap(ov));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1;
    @(posedge clk);
    wr_stb <= 0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1;
    @(posedge clk);
    rd_stb <= 0;
    @(negedge clk);
    v = rdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask
  task settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? sync_out : (s == 1 ? l1h : (s == 2 ? l1l : (l2h | l2l)));
  endfunction
  // counts falling clocks until the chosen output reaches v, bounded
  task waitv(input int s, input logic v, inout int c);
    int b;
    b = 0;
    while (pick(s) !== v && b < 999) begin
      @(negedge clk);
      c++;
      b++;
    end
  endtask
  task gap(input int s, output int c);
    int k;
    k = 0;
    waitv(s, 0, k);
    waitv(s, 1, k);
    c = 0;
    waitv(s, 0, c);
    waitv(s, 1, c);
  endtask
  // both-low cycles between leg1 high falling and leg1 low rising
  task dead(output int c);
    int k;
    k = 0;
    waitv(1, 1, k);
    waitv(1, 0, k);
    c = 0;
    waitv(2, 1, c);
  endtask
  // cycles from leg1 high falling until leg2 enters its gap (both low)
  task lag(output int c);
    int k;
    k = 0;
    waitv(1, 1, k);
    waitv(1, 0, k);
    c = 0;
    waitv(3, 0, c);
  endtask
  task wait_run;
    int k;
    settle(2);
    chk(src, 1);
    k = 0;
    d = 0;
    while (d[4:0] !== ST_RUN && k < 6000) begin
      rd(ADDR_STATUS, d);
      k++;
    end
    chk(d[4:0], ST_RUN);
  endtask

  task t_regs;
    rchk(ADDR_CTRL, 0);
    rchk(ADDR_PERIOD, 100);
    rchk(ADDR_DEL_AB, 10000);
    rchk(ADDR_DEL_CD, 10000);
    rchk(ADDR_SS_DIV, 40);
    rchk(8'h1c, 0);
    wr(ADDR_PERIOD, 0);
    rchk(ADDR_PERIOD, 1);
    wr(ADDR_PERIOD, 100);
    wr(ADDR_SS_DIV, 0);
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CTRL, m);
      rchk(ADDR_CTRL, m);
    end
    wr(ADDR_CTRL, 0);
    $display("registers done");
  endtask
  task t_dead;
    wr(ADDR_DEL_AB, 1000);
    dead(n);
    dead(n);
    chk(n, 3);
    @(posedge clk);
    cs <= 13'h7d0;
    wr(ADDR_DEL_AB, 8000);
    dead(n);
    dead(n);
    chk(n, 5);
    @(posedge clk);
    adaptive_delay_level <= 13'h7d0;
    dead(n);
    dead(n);
    chk(n, 17);
    wr(ADDR_CTRL, 4);
    dead(n);
    dead(n);
    chk(n, 0);
    wr(ADDR_CTRL, 0);
    cs <= 0;
    adaptive_delay_level <= 0;
    $display("dead time done");
  endtask
  task t_noload;
    ea <= 13'h190;
    settle(3);
    chk({l1h, l1l, l2h, l2l}, 0);
    @(posedge clk);
    ea <= 13'h226;
    settle(300);
    chk({l1h, l1l, l2h, l2l}, 0);
    @(posedge clk);
    ea <= 13'h2bc;
    settle(300);
    // the leg may sit in a dead-time gap here, so wait for its high side
    n = 0;
    waitv(1, 1, n);
    chk(l1h | l1l, 1);
    @(posedge clk);
    ea <= 13'h7d0;
    $display("no-load done");
  endtask
  // leg2 trip point: ramp step ea*period/peak, plus one slot to flip
  task t_phase;
    @(posedge clk);
    ea <= 13'h497;
    lag(n);
    lag(n);
    chk(n, 51);
    wr(ADDR_CTRL, 2);
    lag(n);
    lag(n);
    chk(n, 0);
    @(posedge clk);
    ramp <= 13'h7d0;
    lag(n);
    lag(n);
    chk(n, 1);
    @(posedge clk);
    ramp <= 0;
    cs <= 13'h7d0;
    lag(n);
    lag(n);
    chk(n, 1);
    wr(ADDR_CTRL, 0);
    cs <= 0;
    ea <= 13'h7d0;
    $display("phase shift done");
  endtask
  // forced pin, reference loss, lockout: each from full run
  task t_fault;
    logic [3:0] exp[3];
    exp = '{4'b1010, 4'b0110, 4'b0101};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      forced <= i == 0;
      vref <= i == 1 ? 13'hbb8 : 13'h1388;
      supply_undervoltage_lockout <= i == 2;
      settle(2);
      chk({l1h, l1l, l2h, l2l}, 0);
      chk({src, dis, ref_en, lowi}, exp[i]);
      @(posedge clk);
      forced <= 0;
      vref <= 13'h1388;
      supply_undervoltage_lockout <= 0;
      wait_run;
    end
    $display("faults done");
  endtask
  task t_oc;
    logic [31:0] a;
    int k;
    @(posedge clk);
    cs <= 13'ha28;
    settle(2);
    chk({l1h, l1l, l2h, l2l}, 0);
    rd(ADDR_SS_LEVEL, a);
    rd(ADDR_SS_LEVEL, d);
    chk(a - d, 20);
    chk(snk, 1);
    @(posedge clk);
    cs <= 0;
    k = 0;
    while (d[4:0] !== ST_SS && k < 999) begin
      rd(ADDR_STATUS, d);
      k++;
    end
    chk(d[4:0], ST_SS);
    wait_run;
    $display("overcurrent done");
  endtask
  task t_sync;
    gap(0, n);
    chk(n, 100);
    chk(sync_oe, 1);
    gap(1, n);
    chk(n, 200);
    wr(ADDR_CTRL, 16);
    peer <= 1;
    settle(400);
    chk(sync_oe, 0);
    gap(1, n);
    chk(n, 160);
    $display("sync done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_regs;
    wait_run;
    t_dead;
    t_noload;
    t_phase;
    t_fault;
    t_oc;
    t_sync;
    chk(ov, 0);
    test_done;
  end
  initial begin
    #(25 * 90000);
    err_total++;
    test_done;
  end
endmodule
`default_nettype wire
